// File: rtl/i2csa_slave.sv
// Purpose: I2C slave address match and byte receive, APB registers
// Assumes: Software on APB, external master on the I2C wires
// Notes: Transmit side not built; read requests only acknowledged
// Function
// - Stop is SDA rising while SCL high
// - Stop valid only after an SCL low
// - Restart resets receive logic like Start
// - Start/stop enables add flags in plain modes
// - Ninth pulse is acknowledge, low means ack
// - Store sampled ninth-bit level for software
// - Hold enables stretch before ack, drive ack_response_level
// - No ack on overflow, or when buffer full without overwrite enable
// - Ack-time flag after eighth fall, holds only
// - Mode field picks four slave modes
// - Start/stop modes flag every condition
// - First byte matched, else silently idle
// - 7-bit match ignores lowest bit
// - 10-bit header is 11110 A9 A8 0
// - After header ack, flag and hold SCL
// - Low byte always flags, holds till rewrite
// - 10-bit read only after full match
// - Write match clears rw, loads, acks
// - Interrupt flag for each acked byte, software clears
// - Stretch every byte until release set
// - Buffer read clears buffer full
// - Start and stop set status bits
// - Holds set flag, clear release after eighth
`timescale 1ns/1ps
module i2csa_slave
(
	// APB
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// I2C
	i2csa_bus_if.slave       bus
);
	typedef struct packed
	{
		i2csa_pkg::i2csa_sl_state_t sm;
		logic [9:0] ctrl;
		logic [7:0] addr;
		logic [7:0] rxbuf;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic       first;
		logic       hi_seen;
		logic       matched10;
		logic       nack;
		logic       scl_low_seen;
		logic       bf, ov, irq, ua, ack_time_flag, ackst, start, stop, rw, da;
		logic       sda_oe_n;
		logic [31:0] rdata;
	} i2csa_sl_t;
	i2csa_sl_t st;
	i2csa_sl_t next_st;
	logic scl, sda, scl_rise, scl_fall, sda_rise, sda_fall;
	logic wr, rd, is_start, is_stop, hold, sp_mode, ten;
	logic [9:0] status;
	i2csa_sync u_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.scl_raw  (bus.scl_in),
		.sda_raw  (bus.sda_in),
		.scl      (scl),
		.sda      (sda),
		.scl_rise (scl_rise),
		.scl_fall (scl_fall),
		.sda_rise (sda_rise),
		.sda_fall (sda_fall)
	);
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign ten     = st.ctrl[i2csa_pkg::C_MODE_LO];
	assign sp_mode = st.ctrl[i2csa_pkg::C_MODE_LO + 1];
	assign hold    = st.ctrl[i2csa_pkg::C_ADDRESS_HOLD_ENABLE] & ~st.da
		| st.ctrl[i2csa_pkg::C_DATA_HOLD_ENABLE] & st.da;
	assign is_start = sda_fall & scl;
	assign is_stop  = sda_rise & scl & st.scl_low_seen;
	assign status = {st.da, st.rw, st.stop, st.start, st.ackst,
		st.ack_time_flag, st.ua, st.irq, st.ov, st.bf};
	always_comb
	begin
		next_st = st;
		next_st.rdata = 32'h0;
		if (psel && !penable && !pwrite)
		begin
			case (paddr)
				i2csa_pkg::OFF_CTRL:   next_st.rdata = {22'h0, st.ctrl};
				i2csa_pkg::OFF_STATUS: next_st.rdata = {22'h0, status};
				i2csa_pkg::OFF_ADDR:   next_st.rdata = {24'h0, st.addr};
				i2csa_pkg::OFF_RXBUF:  next_st.rdata = {24'h0, st.rxbuf};
				default:               next_st.rdata = 32'h0;
			endcase
		end
		if (scl_fall)
			next_st.scl_low_seen = 1'b1;
		// Software side; hardware sets below win
		if (rd && paddr == i2csa_pkg::OFF_RXBUF)
			next_st.bf = 1'b0;
		if (wr)
		begin
			case (paddr)
				i2csa_pkg::OFF_CTRL: next_st.ctrl = pwdata[9:0];
				i2csa_pkg::OFF_ADDR:
				begin
					next_st.addr = pwdata[7:0];
					next_st.ua = 1'b0;
				end
				i2csa_pkg::OFF_FLAGCLR:
				begin
					if (pwdata[i2csa_pkg::S_IRQ])
						next_st.irq = 1'b0;
					if (pwdata[i2csa_pkg::S_OV])
						next_st.ov = 1'b0;
					if (pwdata[i2csa_pkg::S_START])
						next_st.start = 1'b0;
					if (pwdata[i2csa_pkg::S_STOP])
						next_st.stop = 1'b0;
				end
				default: ;
			endcase
		end
		// Bus state machine
		case (st.sm)
			i2csa_pkg::SL_IDLE: ;
			i2csa_pkg::SL_BITS:
				if (scl_rise)
				begin
					next_st.shift = {st.shift[6:0], sda};
					next_st.cnt = st.cnt + 4'h1;
				end
				else if (scl_fall && st.cnt == 4'h8)
				begin
					logic [7:0] b;
					logic       ok;
					b = st.shift;
					ok = 1'b1;
					if (st.first)
					begin
						if (b[7:3] == i2csa_pkg::TEN_BIT_HDR && ten)
							ok = b[2:1] == st.addr[2:1] &&
								(!b[0] || st.matched10);
						else if (ten)
							ok = 1'b0;
						else
							ok = b[7:1] == st.addr[7:1];
					end
					if (!ok)
						next_st.sm = i2csa_pkg::SL_IGN;
					else
					begin
						if (st.first && !b[0])
							next_st.rw = 1'b0;
						if (st.first && b[0])
							next_st.rw = 1'b1;
						next_st.nack = st.bf | st.ov;
						if (st.bf && !st.ctrl[i2csa_pkg::C_BUFFER_OVERWRITE_ENABLE])
							next_st.ov = 1'b1;
						else
						begin
							next_st.rxbuf = b;
							next_st.bf = 1'b1;
							next_st.nack = st.ov;
						end
						if (st.first && !ten)
							next_st.da = 1'b0;
						if (hold)
						begin
							next_st.irq = 1'b1;
							next_st.ack_time_flag = 1'b1;
							next_st.ctrl[i2csa_pkg::C_CKP] = 1'b0;
							next_st.sm = i2csa_pkg::SL_HOLD8;
						end
						else
						begin
							next_st.sda_oe_n = next_st.nack;
							next_st.sm = i2csa_pkg::SL_ACK;
						end
					end
				end
			i2csa_pkg::SL_HOLD8:
				if (st.ctrl[i2csa_pkg::C_CKP])
				begin
					next_st.nack = st.nack | st.ctrl[i2csa_pkg::C_ACK_RESPONSE_LEVEL];
					next_st.sda_oe_n = st.nack |
						st.ctrl[i2csa_pkg::C_ACK_RESPONSE_LEVEL];
					next_st.sm = i2csa_pkg::SL_ACK;
				end
			i2csa_pkg::SL_ACK:
				if (scl_rise)
					next_st.ackst = sda;
				else if (scl_fall)
				begin
					next_st.sda_oe_n = 1'b1;
					next_st.ack_time_flag = 1'b0;
					next_st.cnt = 4'h0;
					next_st.first = 1'b0;
					if (st.nack)
						next_st.sm = i2csa_pkg::SL_IGN;
					else
					begin
						next_st.irq = 1'b1;
						next_st.sm = i2csa_pkg::SL_BITS;
						if (ten && !st.da)
						begin
							if (st.rw)
								next_st.da = 1'b1;
							else if (!st.hi_seen)
								next_st.hi_seen = 1'b1;
							else
							begin
								next_st.da = 1'b1;
								next_st.matched10 = st.shift == st.addr;
							end
							next_st.ua = !st.rw;
							next_st.sm = i2csa_pkg::SL_HOLD9;
						end
						else if (!ten && !st.da)
							next_st.da = 1'b1;
						if (st.ctrl[i2csa_pkg::C_SEN] || st.rw)
						begin
							next_st.ctrl[i2csa_pkg::C_CKP] = 1'b0;
							next_st.sm = i2csa_pkg::SL_HOLD9;
						end
					end
				end
			i2csa_pkg::SL_HOLD9:
				if (!st.ua && st.ctrl[i2csa_pkg::C_CKP] | !st.rw & st.ua)
				begin
					if (!st.ua)
						next_st.sm = i2csa_pkg::SL_BITS;
				end
			i2csa_pkg::SL_IGN: ;
			default: next_st.sm = i2csa_pkg::SL_IDLE;
		endcase
		// Unmatched low byte ends the transfer once the address is rewritten
		if (st.sm == i2csa_pkg::SL_HOLD9 && !st.ua && ten &&
			st.hi_seen && st.da && !st.matched10)
			next_st.sm = i2csa_pkg::SL_IGN;
		if (is_start)
		begin
			next_st.sm = i2csa_pkg::SL_BITS;
			next_st.cnt = 4'h0;
			next_st.first = 1'b1;
			next_st.hi_seen = 1'b0;
			next_st.da = 1'b0;
			next_st.sda_oe_n = 1'b1;
			next_st.ack_time_flag = 1'b0;
			next_st.scl_low_seen = 1'b0;
			next_st.start = 1'b1;
			next_st.stop = 1'b0;
			if (sp_mode || st.ctrl[i2csa_pkg::C_START_IE])
				next_st.irq = 1'b1;
		end
		else if (is_stop)
		begin
			next_st.sm = i2csa_pkg::SL_IDLE;
			next_st.sda_oe_n = 1'b1;
			next_st.matched10 = 1'b0;
			next_st.stop = 1'b1;
			next_st.start = 1'b0;
			if (sp_mode || st.ctrl[i2csa_pkg::C_STOP_IE])
				next_st.irq = 1'b1;
		end
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.ctrl <= i2csa_pkg::CTRL_RESET;
			st.addr <= i2csa_pkg::ADDR_RESET;
			st.sda_oe_n <= 1'b1;
			st.ackst <= 1'b1;
		end
		else
			st <= next_st;
	end
	assign prdata  = st.rdata;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign bus.sda_oe_n_s = st.sda_oe_n;
	// Stretch: hold states keep SCL low
	assign bus.scl_oe_n_s = !(st.sm == i2csa_pkg::SL_HOLD8 ||
		st.sm == i2csa_pkg::SL_HOLD9);
endmodule

// File: rtl/i2csa_pkg.sv
// Purpose: Shared constants and types for the I2C address-receive slave
// Assumes: 40 MHz pclk, APB with 32-bit data
// Notes: Register offsets are byte addresses
package i2csa_pkg;
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_ADDR    = 8'h08;
	localparam logic [7:0] OFF_RXBUF   = 8'h0c;
	localparam logic [7:0] OFF_FLAGCLR = 8'h10;
	// Control bit positions
	localparam int C_MODE_LO  = 0;
	localparam int C_START_IE = 2;
	localparam int C_STOP_IE  = 3;
	localparam int C_ADDRESS_HOLD_ENABLE     = 4;
	localparam int C_DATA_HOLD_ENABLE     = 5;
	localparam int C_BUFFER_OVERWRITE_ENABLE     = 6;
	localparam int C_SEN      = 7;
	localparam int C_ACK_RESPONSE_LEVEL    = 8;
	localparam int C_CKP      = 9;
	// Status bit positions
	localparam int S_BF     = 0;
	localparam int S_OV     = 1;
	localparam int S_IRQ    = 2;
	localparam int S_UA     = 3;
	localparam int S_ACK_TIME_FLAG = 4;
	localparam int S_ACKST  = 5;
	localparam int S_START  = 6;
	localparam int S_STOP   = 7;
	localparam int S_RW     = 8;
	localparam int S_DA     = 9;
	localparam logic [9:0]  CTRL_RESET = 10'h200;
	localparam logic [7:0]  ADDR_RESET = 8'h00;
	localparam logic [4:0]  TEN_BIT_HDR = 5'h1e;
	// Master clock divider: 100 kHz SCL from 40 MHz, quarter periods
	localparam int SCL_PERIOD_NS = 10000;
	localparam int PCLK_NS       = 25;
	localparam logic [7:0] QTR_CYCLES =
		8'((SCL_PERIOD_NS / 4) / PCLK_NS);
	// Slave modes
	typedef enum logic [1:0]
	{
		MODE_7BIT      = 2'b00,
		MODE_10BIT     = 2'b01,
		MODE_7BIT_SP   = 2'b10,
		MODE_10BIT_SP  = 2'b11
	} i2csa_mode_t;
	typedef enum logic [2:0]
	{
		SL_IDLE  = 3'b000,
		SL_BITS  = 3'b001,
		SL_HOLD8 = 3'b010,
		SL_ACK   = 3'b011,
		SL_HOLD9 = 3'b100,
		SL_IGN   = 3'b101
	} i2csa_sl_state_t;
	typedef enum logic [2:0]
	{
		MS_IDLE  = 3'b000,
		MS_START = 3'b001,
		MS_BIT   = 3'b010,
		MS_ACK   = 3'b011,
		MS_STOP  = 3'b100,
		MS_RSTRT = 3'b101
	} i2csa_ms_state_t;
endpackage

// File: rtl/i2csa_bus_if.sv
// Purpose: Open-drain I2C wires between master and slave ends
// Assumes: Output enable low means the end pulls the line low
// Notes: Pull-up modelled as wired AND of enables
`timescale 1ns/1ps
interface i2csa_bus_if;
	logic scl_in;
	logic scl_out;
	logic scl_oe_n_m;
	logic scl_oe_n_s;
	logic sda_in;
	logic sda_oe_n_m;
	logic sda_oe_n_s;
	assign scl_out = 1'b0;
	assign scl_in = scl_oe_n_m & scl_oe_n_s;
	assign sda_in = sda_oe_n_m & sda_oe_n_s;
	modport slave
	(
		input  scl_in,
		input  sda_in,
		input  scl_out,
		output scl_oe_n_s,
		output sda_oe_n_s
	);
	modport master
	(
		input  scl_in,
		input  sda_in,
		input  scl_out,
		output scl_oe_n_m,
		output sda_oe_n_m
	);
endinterface

// File: rtl/i2csa_sync.sv
// Purpose: Two-flop synchroniser with edge outputs for SCL and SDA
// Assumes: Lines idle high
// Notes: Edges taken from the second and third stages only
`timescale 1ns/1ps
module i2csa_sync
(
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Raw lines
	input  wire logic scl_raw,
	input  wire logic sda_raw,
	// Synchronised levels and edges
	output logic      scl,
	output logic      sda,
	output logic      scl_rise,
	output logic      scl_fall,
	output logic      sda_rise,
	output logic      sda_fall
);
	typedef struct packed
	{
		logic [2:0] scl_sh;
		logic [2:0] sda_sh;
	} i2csa_sync_t;
	i2csa_sync_t st;
	i2csa_sync_t next_st;
	always_comb
	begin
		next_st = st;
		next_st.scl_sh = {st.scl_sh[1:0], scl_raw};
		next_st.sda_sh = {st.sda_sh[1:0], sda_raw};
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '{scl_sh: 3'h7, sda_sh: 3'h7};
		else
			st <= next_st;
	end
	assign scl      = st.scl_sh[1];
	assign sda      = st.sda_sh[1];
	assign scl_rise = st.scl_sh[1] & ~st.scl_sh[2];
	assign scl_fall = ~st.scl_sh[1] & st.scl_sh[2];
	assign sda_rise = st.sda_sh[1] & ~st.sda_sh[2];
	assign sda_fall = ~st.sda_sh[1] & st.sda_sh[2];
endmodule

// File: rtl/i2csa_master.sv
// Purpose: Simple I2C master end writing bytes to the slave
// Assumes: Commands from user port; SCL from divider of pclk
// Notes: Waits while SCL is held low by the slave
`timescale 1ns/1ps
module i2csa_master
(
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// User command
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_kind,
	input  wire logic [7:0] cmd_byte,
	output logic            cmd_ready,
	output logic            ack_seen,
	// I2C
	i2csa_bus_if.master     bus
);
	typedef struct packed
	{
		i2csa_pkg::i2csa_ms_state_t sm;
		logic [7:0] div;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] data;
		logic       scl_oe_n, sda_oe_n, ack;
		logic       scl_s1, scl_s2;
	} i2csa_ms_t;
	i2csa_ms_t st;
	i2csa_ms_t next_st;
	logic tick;
	assign tick = st.div == i2csa_pkg::QTR_CYCLES;
	always_comb
	begin
		next_st = st;
		next_st.scl_s1 = bus.scl_in;
		next_st.scl_s2 = st.scl_s1;
		next_st.div = tick ? 8'h0 : st.div + 8'h1;
		if (st.sm == i2csa_pkg::MS_IDLE && cmd_valid)
		begin
			next_st.ph = 2'h0;
			next_st.bitn = 4'h0;
			next_st.data = cmd_byte;
			case (cmd_kind)
				2'h0: next_st.sm = i2csa_pkg::MS_START;
				2'h1: next_st.sm = i2csa_pkg::MS_BIT;
				2'h2: next_st.sm = i2csa_pkg::MS_STOP;
				default: next_st.sm = i2csa_pkg::MS_RSTRT;
			endcase
		end
		else if (tick && st.sm != i2csa_pkg::MS_IDLE)
		begin
			next_st.ph = st.ph + 2'h1;
			case (st.sm)
				i2csa_pkg::MS_START, i2csa_pkg::MS_RSTRT:
					case (st.ph)
						2'h0: next_st.sda_oe_n = 1'b1;
						2'h1: next_st.scl_oe_n = 1'b1;
						2'h2:
							if (!st.scl_s2)
								next_st.ph = st.ph;
							else
								next_st.sda_oe_n = 1'b0;
						default:
						begin
							next_st.scl_oe_n = 1'b0;
							next_st.sm = i2csa_pkg::MS_IDLE;
						end
					endcase
				i2csa_pkg::MS_BIT, i2csa_pkg::MS_ACK:
					case (st.ph)
						2'h0: next_st.sda_oe_n = st.sm == i2csa_pkg::MS_ACK
							| st.data[7];
						2'h1: next_st.scl_oe_n = 1'b1;
						2'h2:
							if (!st.scl_s2)
								next_st.ph = st.ph;
							else if (st.sm == i2csa_pkg::MS_ACK)
								next_st.ack = !st.scl_s2 ? st.ack : 1'b0;
						default:
						begin
							next_st.scl_oe_n = 1'b0;
							next_st.data = {st.data[6:0], 1'b0};
							next_st.bitn = st.bitn + 4'h1;
							if (st.sm == i2csa_pkg::MS_ACK)
								next_st.sm = i2csa_pkg::MS_IDLE;
							else if (st.bitn == 4'h7)
								next_st.sm = i2csa_pkg::MS_ACK;
						end
					endcase
				i2csa_pkg::MS_STOP:
					case (st.ph)
						2'h0: next_st.sda_oe_n = 1'b0;
						2'h1: next_st.scl_oe_n = 1'b1;
						2'h2:
							if (!st.scl_s2)
								next_st.ph = st.ph;
							else
								next_st.sda_oe_n = 1'b1;
						default: next_st.sm = i2csa_pkg::MS_IDLE;
					endcase
				default: next_st.sm = i2csa_pkg::MS_IDLE;
			endcase
		end
		// Ack sampled in high phase of ninth pulse
		if (st.sm == i2csa_pkg::MS_ACK && st.ph == 2'h2 && tick &&
			st.scl_s2)
			next_st.ack = ~bus.sda_in;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.scl_oe_n <= 1'b1;
			st.sda_oe_n <= 1'b1;
			st.scl_s1 <= 1'b1;
			st.scl_s2 <= 1'b1;
		end
		else
			st <= next_st;
	end
	assign cmd_ready      = st.sm == i2csa_pkg::MS_IDLE;
	assign ack_seen       = st.ack;
	assign bus.scl_oe_n_m = st.scl_oe_n;
	assign bus.sda_oe_n_m = st.sda_oe_n;
endmodule

// File: testbench/i2csa_bus_monitor.sv
// Purpose: Wire checks on the I2C lines joining master and slave
// Assumes: Lines and enables sampled on pclk
// Notes: Rising SCL count restarts on each start condition
`timescale 1ns/1ps
module i2csa_bus_monitor
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Wires and enables
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_oe_n_m,
	input wire logic scl_oe_n_s,
	input wire logic sda_oe_n_m,
	input wire logic sda_oe_n_s
);
	logic [3:0] rises;
	logic [7:0] high_run;
	logic       scl_q;
	logic       sda_q;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////
	// Bit slot count and SCL high run length
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rises <= 4'h0;
			high_run <= 8'h00;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			if (scl_q && scl_in && sda_q && !sda_in)
				rises <= 4'h0;
			else if (!scl_q && scl_in)
				rises <= rises + 4'h1;
			else if (scl_q && !scl_in && rises == 4'h9)
				rises <= 4'h0;
			if (!scl_in)
				high_run <= 8'h00;
			else if (high_run != 8'hff)
				high_run <= high_run + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////
	sequence s_start;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence s_stop;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	a_sda_low_change: assert property ($changed(sda_oe_n_s) |-> !scl_in)
		else $error("slave moved SDA while SCL high");
	a_ack_ninth_slot: assert property ($fell(sda_oe_n_s) |-> rises == 4'h8)
		else $error("slave pulled SDA outside ack slot");
	a_ack_release_end: assert property ($rose(sda_oe_n_s) |-> rises == 4'h0)
		else $error("slave released SDA before ack end");
	a_ack_master_off: assert property (!sda_oe_n_s && scl_in |-> sda_oe_n_m)
		else $error("master drove SDA in ack slot");
	a_ack_held_high: assert property ($rose(scl_in) && !sda_oe_n_s |-> !sda_oe_n_s [*8])
		else $error("ack dropped during SCL high");
	a_stretch_from_low: assert property ($fell(scl_oe_n_s) |-> !$past(scl_in))
		else $error("slave cut an SCL high phase");
	a_master_waits_high: assert property ($fell(scl_oe_n_m) |-> high_run > 8'd50)
		else $error("master pulled SCL without full high phase");
	a_stop_quiet_bus: assert property (s_stop |-> (sda_oe_n_s && scl_oe_n_s) [*4])
		else $error("slave drove bus after stop");
	a_start_fresh_rx: assert property (s_start |=> sda_oe_n_s [*8])
		else $error("slave drove SDA after start");
endmodule

// File: testbench/i2c_slave_addr_receive_tb_top.sv
// Purpose: Master end drives the slave end; software side over APB
// Assumes: pready constant high, master command port as handed over
// Notes: Four tests: 7-bit, start/stop flags, 10-bit header, address hold
`timescale 1ns/1ps
module i2c_slave_addr_receive_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cmd_valid;
	logic [1:0]  cmd_kind;
	logic [7:0]  cmd_byte;
	logic        cmd_ready;
	logic        ack_seen;
	logic [31:0] rd;
	int          err_total;
	int          check_count;
	i2csa_bus_if bus_i();
	i2csa_slave u_i2csa_slave(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_i));
	i2csa_master u_i2csa_master(.pclk(pclk), .presetn(presetn),
		.cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_byte(cmd_byte),
		.cmd_ready(cmd_ready), .ack_seen(ack_seen), .bus(bus_i));
	i2csa_bus_monitor u_i2csa_bus_monitor(.pclk(pclk), .presetn(presetn),
		.scl_in(bus_i.scl_in), .sda_in(bus_i.sda_in),
		.scl_oe_n_m(bus_i.scl_oe_n_m), .scl_oe_n_s(bus_i.scl_oe_n_s),
		.sda_oe_n_m(bus_i.sda_oe_n_m), .sda_oe_n_s(bus_i.sda_oe_n_s));
	////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic bit_chk(input string what, input int pos, input logic exp);
		apb(1'b0, i2csa_pkg::OFF_STATUS, 32'h0);
		check(what, {31'h0, exp}, {31'h0, rd[pos]});
	endtask
	// Kinds: 0 start, 1 byte, 2 stop, 3 restart
	task automatic cmd(input logic [1:0] k, input logic [7:0] b);
		int n;
		@(posedge pclk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_byte <= b;
		do @(posedge pclk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (cmd_ready !== 1'b1 && n < 6000);
		check("command done", 32'h1, {31'h0, cmd_ready});
		repeat (8) @(posedge pclk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial
	begin
		repeat (90000) @(posedge pclk);
		err_total++;
		give_verdict();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, cmd_valid} = 5'h0;
		{paddr, pwdata, cmd_kind, cmd_byte} = 50'h0;
		err_total = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// 7-bit write, full buffer refusal, stop
		rd_chk("ctrl reset", i2csa_pkg::OFF_CTRL, 32'h200);
		rd_chk("addr reset", i2csa_pkg::OFF_ADDR, 32'h0);
		rd_chk("unmapped", 8'h20, 32'h0);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'ha0);
		cmd(2'h0, 8'h00);
		bit_chk("start flag", i2csa_pkg::S_START, 1'b1);
		bit_chk("no start irq", i2csa_pkg::S_IRQ, 1'b0);
		cmd(2'h1, 8'ha0);
		check("addr ack", 32'h1, {31'h0, ack_seen});
		bit_chk("rw clear", i2csa_pkg::S_RW, 1'b0);
		bit_chk("addr irq", i2csa_pkg::S_IRQ, 1'b1);
		rd_chk("rx addr", i2csa_pkg::OFF_RXBUF, 32'ha0);
		bit_chk("bf cleared", i2csa_pkg::S_BF, 1'b0);
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'h4);
		bit_chk("irq cleared", i2csa_pkg::S_IRQ, 1'b0);
		cmd(2'h1, 8'h5a);
		check("data ack", 32'h1, {31'h0, ack_seen});
		cmd(2'h1, 8'h3c);
		check("full nack", 32'h0, {31'h0, ack_seen});
		rd_chk("rx kept", i2csa_pkg::OFF_RXBUF, 32'h5a);
		cmd(2'h2, 8'h00);
		bit_chk("stop flag", i2csa_pkg::S_STOP, 1'b1);
		$display("test 1 done");
		// Start/stop flag mode, lowest bit ignored, restart mismatch
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'hc6);
		apb(1'b1, i2csa_pkg::OFF_CTRL, 32'h202);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'ha1);
		cmd(2'h0, 8'h00);
		bit_chk("start irq", i2csa_pkg::S_IRQ, 1'b1);
		cmd(2'h1, 8'ha0);
		check("lsb ignored", 32'h1, {31'h0, ack_seen});
		rd_chk("rx addr 2", i2csa_pkg::OFF_RXBUF, 32'ha0);
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'hc6);
		cmd(2'h3, 8'h00);
		bit_chk("restart irq", i2csa_pkg::S_IRQ, 1'b1);
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'hc6);
		cmd(2'h1, 8'hb0);
		check("mismatch nack", 32'h0, {31'h0, ack_seen});
		bit_chk("mismatch no load", i2csa_pkg::S_BF, 1'b0);
		bit_chk("mismatch silent", i2csa_pkg::S_IRQ, 1'b0);
		cmd(2'h2, 8'h00);
		bit_chk("stop irq", i2csa_pkg::S_IRQ, 1'b1);
		$display("test 2 done");
		// 10-bit header, hold until address rewrite, low byte
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'hc6);
		apb(1'b1, i2csa_pkg::OFF_CTRL, 32'h201);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'h02);
		cmd(2'h0, 8'h00);
		cmd(2'h1, 8'hf2);
		check("header ack", 32'h1, {31'h0, ack_seen});
		bit_chk("refresh set", i2csa_pkg::S_UA, 1'b1);
		check("scl held", 32'h0, {31'h0, bus_i.scl_oe_n_s});
		rd_chk("rx header", i2csa_pkg::OFF_RXBUF, 32'hf2);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'h77);
		bit_chk("refresh clear", i2csa_pkg::S_UA, 1'b0);
		cmd(2'h1, 8'h77);
		check("low ack", 32'h1, {31'h0, ack_seen});
		bit_chk("refresh again", i2csa_pkg::S_UA, 1'b1);
		rd_chk("rx low", i2csa_pkg::OFF_RXBUF, 32'h77);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'h02);
		cmd(2'h2, 8'h00);
		$display("test 3 done");
		// Address hold: stretch before ack, software answers nack
		apb(1'b1, i2csa_pkg::OFF_FLAGCLR, 32'hc6);
		apb(1'b1, i2csa_pkg::OFF_CTRL, 32'h210);
		apb(1'b1, i2csa_pkg::OFF_ADDR, 32'ha0);
		cmd(2'h0, 8'h00);
		fork
			cmd(2'h1, 8'ha0);
			begin
				while (bus_i.scl_oe_n_s !== 1'b0)
					@(posedge pclk);
				bit_chk("ack time set", i2csa_pkg::S_ACK_TIME_FLAG, 1'b1);
				bit_chk("hold irq", i2csa_pkg::S_IRQ, 1'b1);
				rd_chk("release cleared", i2csa_pkg::OFF_CTRL, 32'h10);
				apb(1'b1, i2csa_pkg::OFF_CTRL, 32'h310);
			end
		join
		check("software nack", 32'h0, {31'h0, ack_seen});
		bit_chk("ack level kept", i2csa_pkg::S_ACKST, 1'b1);
		bit_chk("ack time clear", i2csa_pkg::S_ACK_TIME_FLAG, 1'b0);
		cmd(2'h2, 8'h00);
		$display("test 4 done");
		give_verdict();
	end
endmodule
